// File: hw/prs_regs.svh
/*
 * timing and field constants for the transceiver start-up sequencer pair.
 * assumes a 10 MHz ref_clk_in on both ends; included by bare name.
 */
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define PRS_CLK_HZ 10000000
`define PRS_RESET_MIN_NS 1000
// least time rounds up, never below one cycle
`define PRS_RESET_MIN_CYC ((((`PRS_RESET_MIN_NS * (`PRS_CLK_HZ / 1000000)) + 999) / 1000) < 1 ? 1 : \
    (((`PRS_RESET_MIN_NS * (`PRS_CLK_HZ / 1000000)) + 999) / 1000))
`define PRS_SUPPLY_WAIT_CYC 16
`define PRS_PLL_LOCK_CYC 64
`define PRS_START_LIMIT_CYC 400
`define PRS_REF_CLOCK_IN_DIV 4
`define PRS_CNT_W 16

// ****************************************************************
// data bus values and fields
// ****************************************************************
`define PRS_DATA_W 8
`define PRS_IDLE_DATA 8'h00
`define PRS_UART_LVL_W 2
`define PRS_UART_LVL_DEFAULT 2'h0
`define PRS_IDLE_HOLD_CYC 2

`endif

// File: hw/prs_pkg.sv
/*
 * types shared by both ends of the start-up sequencer.
 * assumes prs_regs.svh is on the include path.
 */
`include "prs_regs.svh"

package prs_pkg;

    typedef enum logic [2:0] {
        PHY_OFF,
        PHY_RESET,
        PHY_SUPPLY,
        PHY_LOCK,
        PHY_WAIT_STOP,
        PHY_RUN
    } prs_phy_state_type;

    typedef enum logic [2:0] {
        LNK_HOLD,
        LNK_RELEASE,
        LNK_WAIT_DIR,
        LNK_IDLE_BUS,
        LNK_RUN
    } prs_link_state_type;

endpackage

// File: hw/prs_ulpi_if.sv
/*
 * pins between the transceiver start-up logic and the link controller.
 * assumes the bench resolves the data bus from the two output enables.
 */
`timescale 1ns/1ps
`default_nettype none
`include "prs_regs.svh"

interface prs_ulpi_if;
    logic chip_reset_n;
    logic ref_clock;
    logic stp;
    logic dir;
    logic [`PRS_DATA_W-1:0] data_phy;
    logic data_phy_oe;
    logic [`PRS_DATA_W-1:0] data_link;
    logic data_link_oe;
    logic [`PRS_DATA_W-1:0] data_bus;

    modport phy (
        input chip_reset_n,
        input ref_clock,
        input stp,
        output dir,
        output data_phy,
        output data_phy_oe,
        input data_bus
    );

    modport link (
        output chip_reset_n,
        output ref_clock,
        output stp,
        input dir,
        output data_link,
        output data_link_oe,
        input data_bus
    );
endinterface

`default_nettype wire

// File: hw/prs_phy.sv
/*
 * transceiver end: regulator enables, register-default reset and the
 * dir hand-off sequence after pll lock.
 * assumes ref_clk_in is the device's local 10 MHz clock; the pins from
 * the link are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "prs_regs.svh"

module prs_phy (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    prs_ulpi_if.phy ulpi,
    input wire logic battery_in,
    input wire logic io_supply_in,
    input wire logic uart_mode_in,
    input wire logic [`PRS_UART_LVL_W-1:0] uart_regulator_level_in,
    output logic regulator_en_out,
    output logic regulated_3v3_out,
    output logic regulated_1v8_out,
    output logic regulator_pulldown_out,
    output logic [`PRS_UART_LVL_W-1:0] uart_regulator_level_out,
    output logic data_pulldown_out,
    output logic regs_default_out,
    output logic sync_mode_out,
    output logic pins_tristate_out,
    output logic running_out,
    output logic start_late_out
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] clk_sync;
        logic [1:0] stp_sync;
        logic clk_prev;
        logic clk_seen;
        prs_pkg::prs_phy_state_type state;
        logic [`PRS_CNT_W-1:0] cnt;
        logic [`PRS_CNT_W-1:0] start_cnt;
        logic regs_default;
        logic late;
        logic [`PRS_UART_LVL_W-1:0] uart_lvl;
    } prs_phy_reg_type;

    prs_phy_reg_type r_q;
    prs_phy_reg_type r_d;

    logic rst_n_s;
    logic clk_s;
    logic stp_s;
    logic clk_rise;
    logic powered;

    assign rst_n_s = r_q.rst_sync[1];
    assign clk_s = r_q.clk_sync[1];
    assign stp_s = r_q.stp_sync[1];
    assign clk_rise = clk_s && !r_q.clk_prev;
    assign powered = battery_in;

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    // one compare for every terminal count keeps the widths in one place
    function automatic logic cnt_done(input logic [`PRS_CNT_W-1:0] cnt,
        input logic [`PRS_CNT_W-1:0] limit);
        return cnt == limit;
    endfunction

    // regulators run in every state but the two reset states
    function automatic logic supply_on(input prs_pkg::prs_phy_state_type st);
        return st != prs_pkg::PHY_OFF && st != prs_pkg::PHY_RESET;
    endfunction

    // dir and the data pull-downs share one decode, so they cannot part
    function automatic logic holds_dir(input prs_pkg::prs_phy_state_type st);
        return st == prs_pkg::PHY_LOCK || st == prs_pkg::PHY_WAIT_STOP;
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        r_d = r_q;
        // all three external pins pass two flops before use
        r_d.rst_sync = {r_q.rst_sync[0], ulpi.chip_reset_n};
        r_d.clk_sync = {r_q.clk_sync[0], ulpi.ref_clock};
        r_d.stp_sync = {r_q.stp_sync[0], ulpi.stp};
        r_d.clk_prev = clk_s;
        r_d.regs_default = 1'b0;
        if (!powered) begin
            r_d.state = prs_pkg::PHY_OFF;
            r_d.clk_seen = 1'b0;
        end else if (!rst_n_s) begin
            // any low time the synchroniser catches resets everything
            r_d.state = prs_pkg::PHY_RESET;
            r_d.clk_seen = 1'b0;
            r_d.cnt = '0;
            r_d.start_cnt = '0;
            r_d.late = 1'b0;
            r_d.uart_lvl = `PRS_UART_LVL_DEFAULT;
        end else begin
            // start interval only runs once clock activity is seen
            if (clk_rise) begin
                r_d.clk_seen = 1'b1;
            end
            // the late flag is sticky: a slow start stays visible in run
            if (r_q.clk_seen && r_q.state != prs_pkg::PHY_RUN) begin
                if (cnt_done(r_q.start_cnt, `PRS_CNT_W'(`PRS_START_LIMIT_CYC))) begin
                    r_d.late = 1'b1;
                end else begin
                    r_d.start_cnt = r_q.start_cnt + 1'b1;
                end
            end
            if (uart_mode_in) begin
                r_d.uart_lvl = uart_regulator_level_in;
            end
            unique case (r_q.state)
                prs_pkg::PHY_OFF, prs_pkg::PHY_RESET: begin
                    r_d.state = prs_pkg::PHY_SUPPLY;
                    r_d.cnt = '0;
                end
                prs_pkg::PHY_SUPPLY: begin
                    if (cnt_done(r_q.cnt, `PRS_CNT_W'(`PRS_SUPPLY_WAIT_CYC))) begin
                        // 1v8 is up: internal reset pulse loads defaults
                        r_d.regs_default = 1'b1;
                        r_d.state = prs_pkg::PHY_LOCK;
                        r_d.cnt = '0;
                    end else begin
                        r_d.cnt = r_q.cnt + 1'b1;
                    end
                end
                prs_pkg::PHY_LOCK: begin
                    // pll only counts lock cycles against a running clock
                    if (cnt_done(r_q.cnt, `PRS_CNT_W'(`PRS_PLL_LOCK_CYC))) begin
                        r_d.state = prs_pkg::PHY_WAIT_STOP;
                    end else if (clk_rise) begin
                        r_d.cnt = r_q.cnt + 1'b1;
                    end
                end
                prs_pkg::PHY_WAIT_STOP: begin
                    // a link still holding stp keeps dir up for as long as it likes
                    if (!stp_s) begin
                        r_d.state = prs_pkg::PHY_RUN;
                    end
                end
                prs_pkg::PHY_RUN: begin
                    r_d.state = prs_pkg::PHY_RUN;
                end
            endcase
        end
    end

    // synchronous clear only; the pin synchronisers restart from zero
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    always_comb begin
        regulator_en_out = supply_on(r_q.state);
        regulated_3v3_out = regulator_en_out;
        regulated_1v8_out = regulator_en_out;
        regulator_pulldown_out = !regulator_en_out;
        uart_regulator_level_out = r_q.uart_lvl;
        data_pulldown_out = holds_dir(r_q.state);
        regs_default_out = r_q.regs_default;
        sync_mode_out = r_q.state == prs_pkg::PHY_RUN;
        // ulpi pins float only when io supply can hold them
        pins_tristate_out = io_supply_in && !regulator_en_out;
        running_out = sync_mode_out && io_supply_in;
        start_late_out = r_q.late;
        ulpi.dir = data_pulldown_out;
        // nothing to send during start-up; the pull-downs hold the bus at 00h
        ulpi.data_phy = `PRS_IDLE_DATA;
        ulpi.data_phy_oe = 1'b0;
    end

endmodule

`default_nettype wire

// File: hw/prs_link.sv
/*
 * link controller end: drives chip reset, makes the reference clock by
 * dividing its own clock, holds stp until ready, then idles the bus.
 * assumes dir arrives asynchronously and is synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "prs_regs.svh"

module prs_link (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    prs_ulpi_if.link ulpi,
    input wire logic start_in,
    input wire logic restart_in,
    input wire logic ready_in,
    output logic bus_ready_out,
    output logic in_reset_out
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [1:0] dir_sync;
        logic [7:0] div;
        logic ref_clock;
        prs_pkg::prs_link_state_type state;
        logic [`PRS_CNT_W-1:0] cnt;
    } prs_link_reg_type;

    prs_link_reg_type r_q;
    prs_link_reg_type r_d;
    logic dir_s;

    assign dir_s = r_q.dir_sync[1];

    always_comb begin
        r_d = r_q;
        r_d.dir_sync = {r_q.dir_sync[0], ulpi.dir};
        if (r_q.div == 8'(`PRS_REF_CLOCK_IN_DIV / 2 - 1)) begin
            r_d.div = 8'h00;
            r_d.ref_clock = !r_q.ref_clock;
        end else begin
            r_d.div = r_q.div + 8'h01;
        end
        unique case (r_q.state)
            prs_pkg::LNK_HOLD: begin
                // reset may stay low as long as the link wishes
                if (start_in && r_q.cnt >= `PRS_CNT_W'(`PRS_RESET_MIN_CYC)) begin
                    r_d.state = prs_pkg::LNK_RELEASE;
                end else if (r_q.cnt != {`PRS_CNT_W{1'b1}}) begin
                    r_d.cnt = r_q.cnt + 1'b1;
                end
            end
            prs_pkg::LNK_RELEASE: begin
                if (dir_s) begin
                    r_d.state = prs_pkg::LNK_WAIT_DIR;
                end
            end
            prs_pkg::LNK_WAIT_DIR: begin
                if (!dir_s && ready_in) begin
                    r_d.state = prs_pkg::LNK_IDLE_BUS;
                    r_d.cnt = '0;
                end
            end
            prs_pkg::LNK_IDLE_BUS: begin
                if (r_q.cnt == `PRS_CNT_W'(`PRS_IDLE_HOLD_CYC)) begin
                    r_d.state = prs_pkg::LNK_RUN;
                end else begin
                    r_d.cnt = r_q.cnt + 1'b1;
                end
            end
            prs_pkg::LNK_RUN: begin
                r_d.state = prs_pkg::LNK_RUN;
            end
        endcase
        if (restart_in) begin
            r_d.state = prs_pkg::LNK_HOLD;
            r_d.cnt = '0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    always_comb begin
        // reset pin is always driven, never left floating
        ulpi.chip_reset_n = r_q.state != prs_pkg::LNK_HOLD;
        ulpi.ref_clock = r_q.ref_clock;
        // stp held until the link is ready to own the bus
        ulpi.stp = !ready_in && r_q.state != prs_pkg::LNK_HOLD;
        ulpi.data_link = `PRS_IDLE_DATA;
        ulpi.data_link_oe = r_q.state == prs_pkg::LNK_IDLE_BUS || r_q.state == prs_pkg::LNK_RUN;
        bus_ready_out = r_q.state == prs_pkg::LNK_RUN;
        in_reset_out = r_q.state == prs_pkg::LNK_HOLD;
    end

endmodule

`default_nettype wire

// File: bench/prs_pair_sva.sv
/* checker on the pins between the two start-up ends.
   assumes one ref_clk_in domain and prs_regs.svh on the include path. */
`include "prs_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module prs_pair_sva (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic chip_reset_n,
    input wire logic ref_clock,
    input wire logic stp,
    input wire logic dir,
    input wire logic [`PRS_DATA_W-1:0] data_phy,
    input wire logic data_phy_oe,
    input wire logic [`PRS_DATA_W-1:0] data_link,
    input wire logic data_link_oe,
    input wire logic [`PRS_DATA_W-1:0] data_bus
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // ************************************************
    // properties
    // ************************************************
    property p_dir_rst; !chip_reset_n [*4] |-> !dir; endproperty
    property p_dir_rise; $rose(chip_reset_n) |-> !dir [*8] ##1 !dir [*8] ##[1:8] dir; endproperty
    property p_lock; $rose(dir) |-> ##250 (dir || !chip_reset_n); endproperty
    property p_stp_hold; dir && stp && chip_reset_n |=> dir; endproperty
    property p_stp_low; $fell(dir) && chip_reset_n |-> !$past(stp, 3); endproperty
    property p_idle; $fell(dir) && chip_reset_n |-> ##[1:6] (data_link_oe && data_bus == 8'h00);
    endproperty
    property p_idle_len; $rose(data_link_oe) |-> (data_link_oe && !dir && data_link == 8'h00) [*3];
    endproperty
    property p_one_drv; data_link_oe |-> !dir && !data_phy_oe; endproperty
    property p_rst_len; $fell(chip_reset_n) |-> !chip_reset_n [*8] ##1 !chip_reset_n ##1 !chip_reset_n;
    endproperty
    property p_div; $rose(ref_clock) |=> !$rose(ref_clock) [*3]; endproperty
    a_dir_rst: assert property (p_dir_rst) else $error("dir high in reset");
    a_dir_rise: assert property (p_dir_rise) else $error("dir rise late or early");
    a_lock: assert property (p_lock) else $error("dir dropped before lock");
    a_stp_hold: assert property (p_stp_hold) else $error("dir fell with stp high");
    a_stp_low: assert property (p_stp_low) else $error("dir fell before stp low");
    a_idle: assert property (p_idle) else $error("bus not idled");
    a_idle_len: assert property (p_idle_len) else $error("idle drive too short");
    a_one_drv: assert property (p_one_drv) else $error("bus contention");
    a_rst_len: assert property (p_rst_len) else $error("reset pulse short");
    a_div: assert property (p_div) else $error("ref clock not divided by 4");
    c_fall: cover property ($fell(dir));
    c_idle: cover property ($rose(data_link_oe));
    c_rst: cover property ($fell(chip_reset_n));
endmodule
`default_nettype wire

// File: bench/tb.sv
/* bench for the transceiver and link start-up ends facing each other.
   assumes the 15k pull-downs settle an undriven data bus to 00h. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, rst = 1, battery = 1, io_sup = 1, uart_md = 0, start = 0, restart = 0, ready = 0;
    logic [1:0] lvl_in = 2'h0;
    logic [1:0] lvl;
    logic reg_en, reg_pd, dpull, regs_def, sync_md, tri_st, running, bus_rdy, in_rst, reg33, reg18;
    logic late;
    int failures = 0, checks = 0, cyc = 0;
    prs_ulpi_if u();
    // undriven bus falls to the pull-down level
    assign u.data_bus = u.data_link_oe ? u.data_link : (u.data_phy_oe ? u.data_phy : 8'h00);
    prs_phy i_prs_phy (.ref_clk_in(clk), .rst_in(rst), .ulpi(u), .battery_in(battery),
        .io_supply_in(io_sup), .uart_mode_in(uart_md), .uart_regulator_level_in(lvl_in),
        .regulator_en_out(reg_en), .regulated_3v3_out(reg33), .regulated_1v8_out(reg18),
        .regulator_pulldown_out(reg_pd), .uart_regulator_level_out(lvl),
        .data_pulldown_out(dpull), .regs_default_out(regs_def), .sync_mode_out(sync_md),
        .pins_tristate_out(tri_st), .running_out(running), .start_late_out(late));
    prs_link i_prs_link (.ref_clk_in(clk), .rst_in(rst), .ulpi(u), .start_in(start),
        .restart_in(restart), .ready_in(ready), .bus_ready_out(bus_rdy), .in_reset_out(in_rst));
    prs_pair_sva i_prs_pair_sva (.ref_clk_in(clk), .rst_in(rst), .chip_reset_n(u.chip_reset_n),
        .ref_clock(u.ref_clock), .stp(u.stp), .dir(u.dir), .data_phy(u.data_phy),
        .data_phy_oe(u.data_phy_oe), .data_link(u.data_link), .data_link_oe(u.data_link_oe),
        .data_bus(u.data_bus));
    initial begin
        forever #50 clk = ~clk;
    end
    // ************************************************
    // checking and closing
    // ************************************************
    task chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task close_out;
        $display("failures %0d checks %0d", failures, checks);
        if (failures == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // bound well above two full start-ups
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            close_out();
        end
    end
    task up;
        for (int i = 0; i < 60 && regs_def !== 1'b1; i++) @(negedge clk);
        chk(8'(regs_def), 8'h01);
    endtask
    // ************************************************
    // scenarios
    // ************************************************
    initial begin
        repeat (8) @(negedge clk);
        rst = 0;
        repeat (40) @(negedge clk);
        // ref clock runs all along, yet nothing may start
        chk(8'({in_rst, reg_en, reg_pd, u.dir}), 8'h0A);
        chk(8'({reg33, reg18}), 8'h00);
        chk(8'(tri_st), 8'h01);
        start = 1;
        up();
        chk(8'(lvl), 8'h00);
        repeat (2) @(negedge clk);
        chk(8'({reg_en, u.dir, dpull, running}), 8'h0E);
        chk(8'({reg33, reg18}), 8'h03);
        repeat (400) @(negedge clk);
        chk(8'({u.dir, bus_rdy}), 8'h02);
        // stp held past the start limit, so the late flag must be up
        chk(8'(late), 8'h01);
        ready = 1;
        for (int i = 0; i < 40 && bus_rdy !== 1'b1; i++) @(negedge clk);
        chk(8'({u.dir, running, sync_md, u.data_link_oe}), 8'h07);
        chk(u.data_bus, 8'h00);
        uart_md = 1;
        lvl_in = 2'h3;
        repeat (3) @(negedge clk);
        uart_md = 0;
        lvl_in = 2'h1;
        repeat (3) @(negedge clk);
        chk(8'(lvl), 8'h03);
        restart = 1;
        @(negedge clk);
        restart = 0;
        repeat (6) @(negedge clk);
        chk(8'({in_rst, reg_en, u.dir}), 8'h04);
        up();
        chk(8'(lvl), 8'h00);
        for (int i = 0; i < 400 && bus_rdy !== 1'b1; i++) @(negedge clk);
        chk(8'(running), 8'h01);
        // a prompt start after the restart stays under the limit
        chk(8'(late), 8'h00);
        io_sup = 0;
        @(negedge clk);
        chk(8'(running), 8'h00);
        battery = 0;
        repeat (3) @(negedge clk);
        chk(8'({reg_en, reg_pd}), 8'h01);
        close_out();
    end
endmodule
`default_nettype wire
